//--- serializer_config_map.svh
/*
 * Constants of the serializer configuration port: latch map, reset
 * values and clock divider counts.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef SERIALIZER_CONFIG_MAP_SVH
`define SERIALIZER_CONFIG_MAP_SVH

// =====================================================================
// Latch array
`define CFG_ADDR_W        3
`define CFG_DATA_W        4
`define CFG_LATCH_COUNT   8
`define CFG_LATCH_RESET   4'h0
`define CFG_CH_LATCH_A    3'h0
`define CFG_CH_LATCH_B    3'h1
`define CFG_RATE_BIT      0
`define CFG_HALF_BIT      1

// =====================================================================
// Channel data and rate range codes
`define CHAR_W            10
`define CHAN_COUNT        2
`define RANGE_LOW         2'h0
`define RANGE_MID         2'h1
`define RANGE_HIGH        2'h2

// =====================================================================
// Reference clock model: 50 MHz system clock, period in ns
`define CLK_PERIOD_NS     20
`define REF_PERIOD_LOW_NS 320
`define REF_PERIOD_MID_NS 160
`define REF_PERIOD_HIGH_NS 80
`define HALF_CYC(ns)      (((ns) / `CLK_PERIOD_NS) / 2)
`define CNT_W             8

`endif

//--- serializer_pkg.sv
/*
 * Types of the serializer configuration port.
 * Assumes serializer_config_map.svh is on the include path.
 */
`include "serializer_config_map.svh"
`default_nettype none

package serializer_pkg;

    // =================================================================
    // Write port sequence, Gray coded
    typedef enum logic [1:0] {
        WR_ARM  = 2'h0,
        WR_IDLE = 2'h1,
        WR_HELD = 2'h3
    } wr_state_type;

    // =================================================================
    // Whole state of the configuration port
    typedef struct packed {
        logic [1:0]                                 strobe_sync;
        logic [1:0][`CFG_ADDR_W-1:0]                addr_sync;
        logic [1:0][`CFG_DATA_W-1:0]                data_sync;
        logic [1:0][`CHAN_COUNT-1:0][1:0]           range_sync;
        logic [1:0][`CHAN_COUNT-1:0][`CHAR_W-1:0]   char_sync;
        wr_state_type                               st;
        logic [`CFG_LATCH_COUNT-1:0][`CFG_DATA_W-1:0] latches;
        logic [`CHAN_COUNT-1:0][`CHAR_W-1:0]        data_out;
    } cfg_state_type;

    // =================================================================
    // Whole state of one channel clock generator
    typedef struct packed {
        logic [`CNT_W-1:0] cnt;
        logic              clk_out;
        logic              char_en;
    } chan_state_type;

endpackage : serializer_pkg

`default_nettype wire

//--- tx_clock_gen.sv
/*
 * One channel's transmit clock generator: divides the system clock to
 * the channel's reference rate or twice it and marks character times.
 * Assumes rate, half-rate and range controls are synchronous to clk.
 */
`include "serializer_config_map.svh"
`default_nettype none

module tx_clock_gen (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       pll_rate_select,
    input  wire logic       half_rate,
    input  wire logic [1:0] range_code,
    output logic            transmit_clock_out,
    output logic            char_enable
);

    serializer_pkg::chan_state_type state_ff;
    serializer_pkg::chan_state_type nxt_state;
    logic [`CNT_W-1:0]              base;
    logic [`CNT_W-1:0]              limit;

    // =================================================================
    // Divider
    always_comb begin
        case (range_code)
            `RANGE_LOW:  base = `CNT_W'(`HALF_CYC(`REF_PERIOD_LOW_NS));
            `RANGE_HIGH: base = `CNT_W'(`HALF_CYC(`REF_PERIOD_HIGH_NS));
            default:     base = `CNT_W'(`HALF_CYC(`REF_PERIOD_MID_NS));
        endcase
        limit = (base >> pll_rate_select) - `CNT_W'(1);
        nxt_state = state_ff;
        nxt_state.char_en = 1'b0;
        if (state_ff.cnt >= limit) begin
            nxt_state.cnt = '0;
            nxt_state.clk_out = ~state_ff.clk_out;
            nxt_state.char_en = half_rate | ~state_ff.clk_out;
        end else begin
            nxt_state.cnt = state_ff.cnt + `CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign transmit_clock_out = state_ff.clk_out;
    assign char_enable        = state_ff.char_en;

    // =================================================================
    // Checks
    // A lower limit ends the running half period early, once
    a_period_exact: assert property (
        @(posedge clk) disable iff (!rst_n)
        (transmit_clock_out != $past(transmit_clock_out) &&
         $past(limit) == $past(limit, 2))
        |-> $past(state_ff.cnt) == $past(limit))
        else $error("clock toggled off the divide count");
    a_full_rate_rise: assert property (
        @(posedge clk) disable iff (!rst_n)
        (char_enable && !$past(half_rate))
        |-> transmit_clock_out && !$past(transmit_clock_out))
        else $error("full rate character mark off rising edge");
    a_half_both: assert property (
        @(posedge clk) disable iff (!rst_n)
        (half_rate && $stable(half_rate) &&
         transmit_clock_out != $past(transmit_clock_out))
        |-> char_enable)
        else $error("half rate edge without character mark");
    c_half_rate: cover property (@(posedge clk) half_rate && char_enable);

endmodule : tx_clock_gen

`default_nettype wire

//--- serializer_config_latch_port.sv
/*
 * Configuration latch port and per-channel transmit control of a
 * dual-channel serializer.
 * Assumes the host drives the asynchronous write port and rate range
 * pins; all pins are synchronised to clk here.
 */
// How it works
// - Each channel clock from its own generator
// - Rate latch 0 reference, 1 double
// - No phase tie to reference clock
// - Async low reset clears all state
// - Reset loads latch init values
// - Range pin selects channel rate range
// - Write strobe copies data to addressed latch
// - Half rate samples on both edges
// - Half rate presents on both edges
`include "serializer_config_map.svh"
`default_nettype none

module serializer_config_latch_port (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  config_write_strobe_n,
    input  wire logic [`CFG_ADDR_W-1:0] config_addr,
    input  wire logic [`CFG_DATA_W-1:0] config_data,
    input  wire logic [1:0]            serial_rate_range_select_a,
    input  wire logic [1:0]            serial_rate_range_select_b,
    input  wire logic [`CHAR_W-1:0]    tx_char_a,
    input  wire logic [`CHAR_W-1:0]    tx_char_b,
    output logic                       transmit_clock_out_a,
    output logic                       transmit_clock_out_b,
    output logic                       char_valid_a,
    output logic                       char_valid_b,
    output logic [`CHAR_W-1:0]         char_out_a,
    output logic [`CHAR_W-1:0]         char_out_b,
    output logic [31:0]                latch_view
);

    serializer_pkg::cfg_state_type     state_ff;
    serializer_pkg::cfg_state_type     nxt_state;
    logic [`CHAN_COUNT-1:0]            tx_clk;
    logic [`CHAN_COUNT-1:0]            char_en;
    logic [`CHAN_COUNT-1:0][`CFG_ADDR_W-1:0] ch_latch;
    logic                              strobe_s;
    logic [`CFG_ADDR_W-1:0]            addr_s;
    logic [`CFG_DATA_W-1:0]            data_s;

    assign ch_latch[0] = `CFG_CH_LATCH_A;
    assign ch_latch[1] = `CFG_CH_LATCH_B;
    assign strobe_s    = state_ff.strobe_sync[1];
    assign addr_s      = state_ff.addr_sync[1];
    assign data_s      = state_ff.data_sync[1];

    // =================================================================
    // Next state
    always_comb begin
        nxt_state = state_ff;
        // Pins are asynchronous; second stage alone is read
        nxt_state.strobe_sync = {state_ff.strobe_sync[0],
                                 config_write_strobe_n};
        nxt_state.addr_sync   = {state_ff.addr_sync[0], config_addr};
        nxt_state.data_sync   = {state_ff.data_sync[0], config_data};
        nxt_state.range_sync[1] = state_ff.range_sync[0];
        nxt_state.range_sync[0] = {serial_rate_range_select_b,
                                   serial_rate_range_select_a};
        nxt_state.char_sync[1] = state_ff.char_sync[0];
        nxt_state.char_sync[0] = {tx_char_b, tx_char_a};
        case (state_ff.st)
            // strobe held low over reset is not a write
            serializer_pkg::WR_ARM: begin
                if (strobe_s) begin
                    nxt_state.st = serializer_pkg::WR_IDLE;
                end
            end
            serializer_pkg::WR_IDLE: begin
                if (!strobe_s) begin
                    nxt_state.latches[addr_s] = data_s;
                    nxt_state.st = serializer_pkg::WR_HELD;
                end
            end
            // One write per strobe, however long it is held
            serializer_pkg::WR_HELD: begin
                if (strobe_s) begin
                    nxt_state.st = serializer_pkg::WR_IDLE;
                end
            end
            default: begin
                nxt_state.st = serializer_pkg::WR_ARM;
            end
        endcase
        for (int c = 0; c < `CHAN_COUNT; c++) begin
            if (char_en[c]) begin
                nxt_state.data_out[c] = state_ff.char_sync[1][c];
            end
        end
    end

    // async clear; latches take init values
    // Strobe chain starts low: a strobe held over reset is no write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= '{strobe_sync: 2'h0,
                          addr_sync:   '0,
                          data_sync:   '0,
                          range_sync:  '0,
                          char_sync:   '0,
                          st:          serializer_pkg::WR_ARM,
                          latches:     {`CFG_LATCH_COUNT{`CFG_LATCH_RESET}},
                          data_out:    '0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    // =================================================================
    // Channels
    // generators free-run; no phase tie to any reference
    // Latch bits reach the generators directly; both sit on clk
    genvar ch;
    generate
        for (ch = 0; ch < `CHAN_COUNT; ch++) begin : g_chan
            tx_clock_gen u_gen (
                .clk                (clk),
                .rst_n              (rst_n),
                .pll_rate_select    (state_ff.latches[ch_latch[ch]]
                                         [`CFG_RATE_BIT]),
                .half_rate          (state_ff.latches[ch_latch[ch]]
                                         [`CFG_HALF_BIT]),
                .range_code         (state_ff.range_sync[1][ch]),
                .transmit_clock_out (tx_clk[ch]),
                .char_enable        (char_en[ch])
            );
        end
    endgenerate

    assign transmit_clock_out_a = tx_clk[0];
    assign transmit_clock_out_b = tx_clk[1];
    assign char_valid_a         = char_en[0];
    assign char_valid_b         = char_en[1];
    assign char_out_a           = state_ff.data_out[0];
    assign char_out_b           = state_ff.data_out[1];
    assign latch_view           = state_ff.latches;

    // =================================================================
    // Write port checks
    a_reset_clear: assert property (
        @(posedge clk) (!rst_n && !$past(rst_n))
        |-> state_ff.latches == {`CFG_LATCH_COUNT{`CFG_LATCH_RESET}} &&
            state_ff.st == serializer_pkg::WR_ARM)
        else $error("reset did not clear latches and write port");
    a_state_legal: assert property (
        @(posedge clk) disable iff (!rst_n)
        state_ff.st inside {serializer_pkg::WR_ARM, serializer_pkg::WR_IDLE,
                            serializer_pkg::WR_HELD})
        else $error("write port state outside its code set");
    a_write_loads: assert property (
        @(posedge clk) disable iff (!rst_n)
        (state_ff.st == serializer_pkg::WR_IDLE && !strobe_s)
        |=> state_ff.latches[$past(addr_s)] == $past(data_s))
        else $error("write did not load addressed latch");
    a_latch_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        !(state_ff.st == serializer_pkg::WR_IDLE && !strobe_s)
        |=> $stable(state_ff.latches))
        else $error("latch changed without a taken strobe");
    a_arm_no_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        state_ff.st == serializer_pkg::WR_ARM
        |=> $stable(state_ff.latches))
        else $error("latch changed before write port armed");
    a_arm_exit: assert property (
        @(posedge clk) disable iff (!rst_n)
        (state_ff.st == serializer_pkg::WR_ARM && !strobe_s)
        |=> state_ff.st == serializer_pkg::WR_ARM)
        else $error("write port armed while strobe still low");
    a_held_one_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        state_ff.st == serializer_pkg::WR_HELD
        |=> $stable(state_ff.latches))
        else $error("second write within one strobe");
    // Pin fall reaches the state three edges later through the sync
    a_strobe_latency: assert property (
        @(posedge clk) disable iff (!rst_n)
        (state_ff.st == serializer_pkg::WR_IDLE && config_write_strobe_n)
        ##1 !config_write_strobe_n
        |-> ##3 state_ff.st == serializer_pkg::WR_HELD)
        else $error("strobe not taken three cycles after pin fall");

    // =================================================================
    // Channel checks
    a_char_capture: assert property (
        @(posedge clk) disable iff (!rst_n)
        char_en[0] |=> char_out_a == $past(state_ff.char_sync[1][0]))
        else $error("channel character not captured on mark");
    a_char_capture_b: assert property (
        @(posedge clk) disable iff (!rst_n)
        char_en[1] |=> char_out_b == $past(state_ff.char_sync[1][1]))
        else $error("second channel character not captured on mark");
    a_char_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        !char_en[1] |=> $stable(char_out_b))
        else $error("channel output moved without mark");
    a_char_hold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !char_en[0] |=> $stable(char_out_a))
        else $error("first channel output moved without mark");

    // =================================================================
    // Coverage
    c_arm_blocked: cover property (@(posedge clk) disable iff (!rst_n)
        state_ff.st == serializer_pkg::WR_ARM && !strobe_s);
    c_write: cover property (@(posedge clk) disable iff (!rst_n)
        state_ff.st == serializer_pkg::WR_HELD);
    c_rate_double: cover property (@(posedge clk) disable iff (!rst_n)
        state_ff.latches[`CFG_CH_LATCH_A][`CFG_RATE_BIT] && char_en[0]);
    c_range_high: cover property (@(posedge clk) disable iff (!rst_n)
        state_ff.range_sync[1][1] == `RANGE_HIGH && char_en[1]);

endmodule : serializer_config_latch_port

`default_nettype wire

//--- cfg_host_model.sv
/*
 * Behavioural host on the configuration write port of the serializer.
 * Assumes the bench raises go for one pulse and watches busy; all pin
 * changes land on the falling edge of clk.
 */
`default_nettype none

module cfg_host_model (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [2:0] wr_addr,
    input  wire logic [3:0] wr_data,
    output logic            busy,
    output logic            config_write_strobe_n,
    output logic [2:0]      config_addr,
    output logic [3:0]      config_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // =================================================================
    // Write cycle; one process owns every pin
    initial begin
        busy                  = 1'b0;
        config_write_strobe_n = 1'b1;
        config_addr           = 3'h7;
        config_data           = 4'hF;
        forever begin
            @(posedge clk);
            if (go === 1'b1) begin
                @(negedge clk);
                busy        = 1'b1;
                config_addr = wr_addr;
                config_data = wr_data;
                @(negedge clk);
                config_write_strobe_n = 1'b0;
                repeat (4) @(negedge clk);
                config_write_strobe_n = 1'b1;
                @(negedge clk);
                // Released pins float to their pull-up level
                config_addr = 3'h7;
                config_data = 4'hF;
                repeat (4) @(negedge clk);
                busy = 1'b0;
            end
        end
    end
endmodule : cfg_host_model

`default_nettype wire

//--- serializer_config_latch_port_tb.sv
/*
 * Self-checking bench of the serializer configuration port.
 * Assumes the design files and cfg_host_model.sv are compiled first.
 */
`include "serializer_config_map.svh"
`default_nettype none

module serializer_config_latch_port_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst_n, go, busy, strobe_n, chk_en;
    logic [2:0] h_addr, c_addr;
    logic [3:0] h_data, c_data;
    logic [1:0] rng [2];
    logic [`CHAR_W-1:0] tx [2];
    logic [`CHAR_W-1:0] cho [2];
    logic [1:0] tclk, cv, prev_tclk, prev_cv, half;
    logic [31:0] latch_view, prev_view, exp_view;
    logic [31:0] exp_q [$];
    logic [7:0] rnd;
    int fail_count, n_compared;

    serializer_config_latch_port i_serializer_config_latch_port (
        .clk(clk), .rst_n(rst_n), .config_write_strobe_n(strobe_n),
        .config_addr(c_addr), .config_data(c_data),
        .serial_rate_range_select_a(rng[0]),
        .serial_rate_range_select_b(rng[1]),
        .tx_char_a(tx[0]), .tx_char_b(tx[1]),
        .transmit_clock_out_a(tclk[0]), .transmit_clock_out_b(tclk[1]),
        .char_valid_a(cv[0]), .char_valid_b(cv[1]),
        .char_out_a(cho[0]), .char_out_b(cho[1]),
        .latch_view(latch_view));

    cfg_host_model i_cfg_host_model (
        .clk(clk), .go(go), .wr_addr(h_addr), .wr_data(h_data),
        .busy(busy), .config_write_strobe_n(strobe_n),
        .config_addr(c_addr), .config_data(c_data));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic check(input logic [31:0] seen, exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t %s seen %h exp %h",
                     $time, what, seen, exp);
        end
    endtask : check

    task automatic summarize;
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize

    // =================================================================
    // Host write; in reset nothing is expected to change
    task automatic write(input logic [2:0] a, input logic [3:0] d);
        int i;
        if (rst_n === 1'b1 && exp_view[a*4+:4] === d) return;
        if (rst_n === 1'b1) begin
            exp_view[a*4+:4] = d;
            exp_q.push_back(exp_view);
        end
        @(negedge clk);
        go = 1'b1; h_addr = a; h_data = d;
        @(posedge clk);
        @(negedge clk);
        go = 1'b0;
        repeat (2) @(negedge clk);
        i = 0;
        while (busy === 1'b1 && i < 50) begin
            @(posedge clk);
            i++;
        end
        if (i >= 50) check(1, 0, "host write hung");
    endtask : write

    // Rising edges of one channel clock, cycles between two of them
    task automatic measure(input int ch, output int n);
        logic p;
        int i;
        n = 0;
        for (i = 0; i < 2; i++) begin
            p = tclk[ch];
            @(negedge clk);
            while (!(tclk[ch] === 1'b1 && p === 1'b0) && n < 400) begin
                p = tclk[ch];
                n = (i == 1) ? n + 1 : n;
                @(negedge clk);
            end
        end
        n = n + 1;
    endtask : measure

    function automatic int half_per(input logic [1:0] r, input logic t);
        return (r == 2'h0 ? 8 : (r == 2'h2 ? 2 : 4)) >> t;
    endfunction : half_per

    // =================================================================
    // Character and latch monitors
    always @(negedge clk) begin
        for (int c = 0; c < 2; c++) begin
            if (chk_en) begin
                check(cv[c], half[c] ? tclk[c] ^ prev_tclk[c]
                      : tclk[c] & ~prev_tclk[c], "char valid");
                if (prev_cv[c]) check(cho[c], tx[c], "char out");
            end
        end
        prev_tclk = tclk;
        prev_cv   = cv;
    end

    always @(negedge clk) begin
        if (rst_n === 1'b1 && latch_view !== prev_view) begin
            if (exp_q.size() == 0) begin
                check(latch_view, prev_view, "unexp");
            end else begin
                check(latch_view, exp_q.pop_front(), "latch view");
            end
        end
        prev_view = latch_view;
    end

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        check(1, 0, "watchdog");
        summarize();
    end

    // =================================================================
    // Main sequence
    initial begin
        int n;
        logic [1:0] r;
        rst_n = 1'b0; go = 1'b0; h_addr = 3'h0; h_data = 4'h0;
        chk_en = 1'b0; half = 2'h0; exp_view = {8{`CFG_LATCH_RESET}};
        rng[0] = 2'h0; rng[1] = 2'h0; tx[0] = '0; tx[1] = '0;
        prev_view = '0; rnd = 8'h59;
        fail_count = 0; n_compared = 0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        check(latch_view, {8{`CFG_LATCH_RESET}}, "reset view");
        repeat (6) @(negedge clk);
        // each channel set on its own
        for (int i = 0; i < 8; i++) begin
            r = i[1:0];
            chk_en = 1'b0;
            // range pins static within a step
            rng[0] = r;
            rng[1] = 2'h3 - r;
            half = {~i[0], i[0] ^ i[2]};
            rnd = lfsr(rnd);
            tx[0] = {rnd[1:0], rnd};
            tx[1] = ~{rnd, rnd[7:6]};
            write(3'h0, {2'h0, half[0], i[2]});
            write(3'h1, {2'h0, half[1], ~i[2]});
            repeat (60) @(negedge clk);
            chk_en = 1'b1;
            measure(0, n);
            check(n, 2 * half_per(r, i[2]), "period a");
            measure(1, n);
            check(n, 2 * half_per(2'h3 - r, ~i[2]), "period b");
            repeat (40) @(negedge clk);
            chk_en = 1'b0;
            $display("Test clock step %0d done", i);
        end
        for (int a = 0; a < 8; a++) begin
            rnd = lfsr(rnd);
            write(a[2:0], rnd[3:0]);
        end
        repeat (4) @(negedge clk);
        $display("Test latch writes done");
        #3 rst_n = 1'b0;
        #1;
        check(latch_view, {8{`CFG_LATCH_RESET}}, "async clear");
        check({tclk, cv}, 4'h0, "outputs in reset");
        // write during reset, then a strobe held across release
        write(3'h2, 4'hA);
        fork
            write(3'h3, 4'h5);
            begin
                repeat (3) @(negedge clk);
                rst_n = 1'b1;
            end
        join
        repeat (20) @(negedge clk);
        check(latch_view, {8{`CFG_LATCH_RESET}}, "reset write");
        $display("Test reset done");
        summarize();
    end
endmodule : serializer_config_latch_port_tb

`default_nettype wire
